// ==== sid_consts.vh ====
// sid_consts.vh: constants for the status indicator driver
// assumes: 25 MHz system clock, registers reached over the plain strobe port
`ifndef SID_CONSTS_VH
`define SID_CONSTS_VH

// register offsets (byte addresses, one word each)
`define SID_OFF_CTRL 8'h00
`define SID_OFF_STAT 8'h04
`define SID_OFF_IRQ 8'h08
`define SID_OFF_MASK 8'h0C
`define SID_OFF_FAULT 8'h10

// control register fields
`define SID_CTRL_CARD_FITTED 0
`define SID_CTRL_HOST_STARTED 1
`define SID_CTRL_PORT1_PRESENT 2
`define SID_CTRL_RESET 8'h04

// interrupt status fields
`define SID_IRQ_MAJOR 0
`define SID_IRQ_RECOV 1
`define SID_IRQ_BADFS 2
`define SID_IRQ_W 3

// fault codes
`define SID_FAULT_NO_CARD 8'h3C
`define SID_FAULT_CARD 8'h3D

// flash half period
`define SID_TOGGLE_MS 250
`define SID_CLK_KHZ 25000
`define SID_TOGGLE_CYC (`SID_TOGGLE_MS * `SID_CLK_KHZ)

`endif

// ==== sid_status_lights.v ====
// sid_status_lights.v: front-panel status light driver with a small register port
// assumes: status flags from the controller core share clk_i; lights are active-high
//
// Notes on behaviour
// R1: health light flashes green during nonvolatile project store or load.
// R2: nonrecoverable major fault clears project and holds health light steady red.
// R3: recoverable major fault with no card fitted reports fault code 60.
// R4: card light is off when the card has no read or write activity.
// R5: card light flashes green while the card is read or written.
// R6: card light flashes red when the card lacks a valid file system.
// R7: default-config light is off when port 0 settings differ from default.
// R8: default-config light is steady green while port 0 holds default settings.
// R9: each port traffic light flashes green on activity; second port optional.
// R10: steady patterns drive the light continuously without toggling.
// R11: alternating pairs toggle and always stay in opposite states.
// R12: flashing lights toggle; flashing pairs toggle together, in phase.
// R13: module-state light flashes green once the host has started the card.
// R14: the card accepts local host messages even when detached from network.
// R15: one shared toggle timer drives all flashing and alternating patterns.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "sid_consts.vh"

module sid_status_lights #(
    parameter TOGGLE_CYC = `SID_TOGGLE_CYC
) (
    input wire clk_i,
    input wire nrst_i,
    input wire nv_busy_i,
    input wire major_fault_i,
    input wire recov_fault_i,
    input wire card_busy_i,
    input wire card_bad_fs_i,
    input wire port0_default_i,
    input wire port0_activity_i,
    input wire port1_activity_i,
    input wire selftest_i,
    input wire local_msg_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg health_green_o,
    output reg health_red_o,
    output reg card_activity_light_green_o,
    output reg card_activity_light_red_o,
    output reg default_port_config_light_o,
    output reg port0_traffic_light_o,
    output reg port1_traffic_light_o,
    output reg module_state_light_green_o,
    output reg module_state_light_red_o,
    output reg project_clear_o,
    output reg local_msg_ack_o,
    output reg irq_o
);

    reg [31:0] tmr_r;
    reg phase_r;
    reg [7:0] ctrl_r;
    reg [`SID_IRQ_W-1:0] irq_stat_r;
    reg [`SID_IRQ_W-1:0] irq_stat_nxt;
    reg [`SID_IRQ_W-1:0] mask_r;
    reg [7:0] fault_code_r;
    reg major_latch_r;
    reg [2:0] hl_state_r;
    reg [2:0] hl_state_nxt;
    reg [3:0] ms_state_r;
    reg [3:0] ms_state_nxt;
    wire [`SID_IRQ_W-1:0] ev_src;
    wire [`SID_IRQ_W-1:0] ev;
    wire card_fitted;
    wire host_started;

    // health light states, one-hot
    localparam [2:0] HL_RUN = 3'h1;
    localparam [2:0] HL_STORE = 3'h2;
    localparam [2:0] HL_FAULT = 3'h4;

    // module-state light states, one-hot
    localparam [3:0] MS_IDLE = 4'h1;
    localparam [3:0] MS_RUN = 4'h2;
    localparam [3:0] MS_TEST = 4'h4;
    localparam [3:0] MS_FAULT = 4'h8;

    assign card_fitted = ctrl_r[`SID_CTRL_CARD_FITTED];
    assign host_started = ctrl_r[`SID_CTRL_HOST_STARTED];

    // single timer so every flashing light shares one phase [R15]
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            tmr_r <= 32'h00000000;
            phase_r <= 1'b0;
        end else if (tmr_r >= TOGGLE_CYC - 1) begin
            tmr_r <= 32'h00000000;
            phase_r <= ~phase_r; // [R12]
        end else begin
            tmr_r <= tmr_r + 32'h00000001;
        end
    end

    // rising edges of the fault and file-system flags are events, one detector per bit;
    // detectors reset low, the idle level of every flag, so no false event follows reset
    assign ev_src[`SID_IRQ_MAJOR] = major_fault_i;
    assign ev_src[`SID_IRQ_RECOV] = recov_fault_i;
    assign ev_src[`SID_IRQ_BADFS] = card_bad_fs_i;

    genvar gi;
    generate
        for (gi = 0; gi < `SID_IRQ_W; gi = gi + 1) begin : g_edge
            reg prev_r;
            always @(posedge clk_i) begin
                if (!nrst_i) begin
                    prev_r <= 1'b0;
                end else begin
                    prev_r <= ev_src[gi];
                end
            end
            assign ev[gi] = ev_src[gi] & ~prev_r;
        end
    endgenerate

    // a nonrecoverable fault is held until reset; the project clear pulses for one cycle on each rising edge
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            major_latch_r <= 1'b0;
            project_clear_o <= 1'b0;
            fault_code_r <= 8'h00;
        end else begin
            if (ev[`SID_IRQ_MAJOR])
                major_latch_r <= 1'b1;
            project_clear_o <= ev[`SID_IRQ_MAJOR]; // [R2]
            if (ev[`SID_IRQ_RECOV])
                fault_code_r <= card_fitted ? `SID_FAULT_CARD : `SID_FAULT_NO_CARD; // [R3]
        end
    end

    // health light sequencing; the fault state is a sink that only reset leaves,
    // so the red light cannot be lost while the project is being cleared
    always @* begin
        hl_state_nxt = hl_state_r;
        case (hl_state_r)
            HL_RUN: begin
                if (ev[`SID_IRQ_MAJOR])
                    hl_state_nxt = HL_FAULT;
                else if (nv_busy_i)
                    hl_state_nxt = HL_STORE;
            end
            HL_STORE: begin
                if (ev[`SID_IRQ_MAJOR])
                    hl_state_nxt = HL_FAULT;
                else if (!nv_busy_i)
                    hl_state_nxt = HL_RUN;
            end
            HL_FAULT: begin
                hl_state_nxt = HL_FAULT;
            end
            // an upset code falls to the safe red state rather than a false green
            default: begin
                hl_state_nxt = HL_FAULT;
            end
        endcase
    end

    // module-state light follows a fixed priority; a major fault is final until reset
    always @* begin
        ms_state_nxt = ms_state_r;
        case (ms_state_r)
            MS_IDLE, MS_RUN, MS_TEST: begin
                if (major_latch_r)
                    ms_state_nxt = MS_FAULT;
                else if (selftest_i)
                    ms_state_nxt = MS_TEST;
                else if (host_started)
                    ms_state_nxt = MS_RUN;
                else
                    ms_state_nxt = MS_IDLE;
            end
            MS_FAULT: begin
                ms_state_nxt = MS_FAULT;
            end
            default: begin
                ms_state_nxt = MS_FAULT;
            end
        endcase
    end

    // state registers; the lights decode the next state so most lights keep
    // one cycle of latency from their input flag; module-state red takes two after a major fault
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            hl_state_r <= HL_RUN;
            ms_state_r <= MS_IDLE;
        end else begin
            hl_state_r <= hl_state_nxt;
            ms_state_r <= ms_state_nxt;
        end
    end

    // read clears status, but a same-cycle event still sets its bit
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (rd_i && addr_i == `SID_OFF_IRQ)
            irq_stat_nxt = {`SID_IRQ_W{1'b0}};
        irq_stat_nxt = irq_stat_nxt | ev;
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_r <= `SID_CTRL_RESET;
            mask_r <= {`SID_IRQ_W{1'b0}};
            irq_stat_r <= {`SID_IRQ_W{1'b0}};
            rdata_o <= 32'h00000000;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_o <= |(irq_stat_nxt & mask_r);
            if (wr_i) begin
                case (addr_i)
                    `SID_OFF_CTRL: ctrl_r <= wdata_i[7:0];
                    `SID_OFF_MASK: mask_r <= wdata_i[`SID_IRQ_W-1:0];
                    default: ;
                endcase
            end
            rdata_o <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                    `SID_OFF_CTRL: rdata_o <= {24'h000000, ctrl_r};
                    `SID_OFF_STAT: rdata_o <= {22'h000000, selftest_i, card_bad_fs_i, card_busy_i,
                                               nv_busy_i, port1_activity_i, port0_activity_i,
                                               port0_default_i, major_latch_r, host_started, phase_r};
                    `SID_OFF_IRQ: rdata_o <= {29'h00000000, irq_stat_r};
                    `SID_OFF_MASK: rdata_o <= {29'h00000000, mask_r};
                    `SID_OFF_FAULT: rdata_o <= {24'h000000, fault_code_r};
                    default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // light drivers; steady states hold a constant level [R10]
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            health_green_o <= 1'b0;
            health_red_o <= 1'b0;
            card_activity_light_green_o <= 1'b0;
            card_activity_light_red_o <= 1'b0;
            default_port_config_light_o <= 1'b0;
            port0_traffic_light_o <= 1'b0;
            port1_traffic_light_o <= 1'b0;
            module_state_light_green_o <= 1'b0;
            module_state_light_red_o <= 1'b0;
            local_msg_ack_o <= 1'b0;
        end else begin
            case (hl_state_nxt)
                HL_FAULT: begin
                    health_green_o <= 1'b0;
                    health_red_o <= 1'b1; // [R2]
                end
                HL_STORE: begin
                    health_green_o <= phase_r; // [R1]
                    health_red_o <= 1'b0;
                end
                default: begin
                    health_green_o <= 1'b1; // [R10]
                    health_red_o <= 1'b0;
                end
            endcase
            // bad file system outranks activity: data there is unusable anyway
            case ({card_bad_fs_i, card_busy_i})
                2'h2, 2'h3: begin
                    card_activity_light_green_o <= 1'b0;
                    card_activity_light_red_o <= phase_r; // [R6]
                end
                2'h1: begin
                    card_activity_light_green_o <= phase_r; // [R5]
                    card_activity_light_red_o <= 1'b0;
                end
                default: begin
                    card_activity_light_green_o <= 1'b0; // [R4]
                    card_activity_light_red_o <= 1'b0;
                end
            endcase
            default_port_config_light_o <= port0_default_i; // [R7] [R8]
            port0_traffic_light_o <= port0_activity_i & phase_r; // [R9]
            port1_traffic_light_o <= ctrl_r[`SID_CTRL_PORT1_PRESENT] & port1_activity_i & phase_r; // [R9]
            // both halves of the pair read the one phase bit, so they cannot drift apart
            case (ms_state_nxt)
                MS_FAULT: begin
                    module_state_light_green_o <= 1'b0;
                    module_state_light_red_o <= 1'b1; // [R10]
                end
                MS_TEST: begin
                    module_state_light_green_o <= ~phase_r; // [R11]
                    module_state_light_red_o <= phase_r; // [R11]
                end
                MS_RUN: begin
                    module_state_light_green_o <= phase_r; // [R13]
                    module_state_light_red_o <= 1'b0;
                end
                default: begin
                    module_state_light_green_o <= 1'b0;
                    module_state_light_red_o <= 1'b0;
                end
            endcase
            // no network gating: detached cards still take host messages
            local_msg_ack_o <= local_msg_i & host_started; // [R14]
        end
    end

endmodule // sid_status_lights

// ==== sid_status_lights_assertions.sv ====
// sid_status_lights_assertions.sv: port checks for the status light driver
// assumes: bound onto sid_status_lights; one clock, sync active-low reset
`timescale 1ns/1ns
module sid_chk (
    input wire clk_i,
    input wire nrst_i,
    input wire major_fault_i,
    input wire nv_busy_i,
    input wire card_busy_i,
    input wire card_bad_fs_i,
    input wire port0_default_i,
    input wire port0_activity_i,
    input wire health_green_o,
    input wire health_red_o,
    input wire card_activity_light_green_o,
    input wire default_port_config_light_o,
    input wire port0_traffic_light_o,
    input wire project_clear_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_pulse;
        project_clear_o ##1 !project_clear_o;
    endsequence
    sequence s_card_idle;
        (!card_busy_i && !card_bad_fs_i) [*3];
    endsequence
    red_after_fault_a: assert property ($rose(major_fault_i) |-> ##[1:2] health_red_o)
        else $error("health light not red after major fault");
    red_latch_a: assert property (health_red_o |=> health_red_o && !health_green_o)
        else $error("health red dropped");
    clear_pulse_a: assert property ($rose(major_fault_i) |=> s_pulse)
        else $error("project clear pulse wrong");
    card_idle_off_a: assert property (s_card_idle |-> !card_activity_light_green_o)
        else $error("card light on while idle");
    dcfg_on_a: assert property (port0_default_i [*3] |-> default_port_config_light_o)
        else $error("default config light off");
    dcfg_off_a: assert property (!port0_default_i [*3] |-> !default_port_config_light_o)
        else $error("default config light on");
    steady_green_a: assert property ((!nv_busy_i && !major_fault_i && !health_red_o) [*3] |-> health_green_o)
        else $error("health green not steady");
    flash_phase_a: assert property ((card_busy_i && !card_bad_fs_i && port0_activity_i) [*3]
        |-> card_activity_light_green_o == port0_traffic_light_o)
        else $error("flashing lights out of phase");
endmodule // sid_chk

// ==== sid_status_lights_tb.sv ====
// sid_status_lights_tb.sv: self-checking bench for the status light driver
// assumes: toggle period shortened to 4 cycles; checker bound at the foot
`timescale 1ns/1ns
`include "sid_consts.vh"
module sid_status_lights_tb;
    logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
    logic [9:0] in_v = 0;
    logic [7:0] addr_i = 0;
    logic [31:0] wdata_i = 0;
    wire [31:0] rdata_o;
    wire [8:0] lt;
    wire clr, ack, irq;
    int fails = 0, total_checks = 0, cyc = 0;
    sid_status_lights #(.TOGGLE_CYC(4)) sid_status_lights_inst (.clk_i, .nrst_i, .nv_busy_i(in_v[0]),
        .major_fault_i(in_v[1]), .recov_fault_i(in_v[2]), .card_busy_i(in_v[3]), .card_bad_fs_i(in_v[4]),
        .port0_default_i(in_v[5]), .port0_activity_i(in_v[6]), .port1_activity_i(in_v[7]),
        .selftest_i(in_v[8]), .local_msg_i(in_v[9]), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .health_green_o(lt[0]), .health_red_o(lt[1]), .card_activity_light_green_o(lt[2]),
        .card_activity_light_red_o(lt[3]), .default_port_config_light_o(lt[4]), .port0_traffic_light_o(lt[5]),
        .port1_traffic_light_o(lt[6]), .module_state_light_green_o(lt[7]), .module_state_light_red_o(lt[8]),
        .project_clear_o(clr), .local_msg_ack_o(ack), .irq_o(irq));
    initial forever #20 clk_i = ~clk_i;
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a hung bench still reaches the verdict
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2500) begin
            fails++;
            conclude;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic set(input int b, input logic v);
        @(posedge clk_i);
        in_v[b] <= v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1 chk(rdata_o, e);
    endtask
    // counts light changes over 16 cycles after settling; 4 means flashing
    task automatic tog(input int b, input int n);
        int k;
        logic p;
        k = 0;
        repeat (8) @(posedge clk_i);
        #1 p = lt[b];
        repeat (16) begin
            @(posedge clk_i);
            #1 if (lt[b] !== p || $isunknown(lt[b])) k++;
            p = lt[b];
        end
        chk(k, n);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'h1;
        rd(`SID_OFF_CTRL, 32'h4);
        rd(`SID_OFF_MASK, 32'h0);
        set(5, 1);
        tog(0, 0);
        chk(lt[0], 1'h1);
        chk(lt[4], 1'h1);
        set(5, 0);
        tog(4, 0);
        chk(lt[4], 1'h0);
        set(0, 1);
        tog(0, 4);
        set(0, 0);
        set(6, 1);
        set(7, 1);
        tog(5, 4);
        tog(6, 4);
        set(6, 0);
        tog(5, 0);
        wr(`SID_OFF_CTRL, 32'h0);
        tog(6, 0);
        set(7, 0);
        $display("health and serial lights done");
        set(3, 1);
        set(6, 1);
        tog(2, 4);
        set(3, 0);
        tog(2, 0);
        chk(lt[2], 1'h0);
        set(4, 1);
        tog(3, 4);
        chk(irq, 1'h0);
        wr(`SID_OFF_MASK, 32'h4);
        @(posedge clk_i);
        #1 chk(irq, 1'h1);
        rd(`SID_OFF_IRQ, 32'h4);
        @(posedge clk_i);
        #1 chk(irq, 1'h0);
        set(4, 0);
        rd(8'h20, 32'h0);
        $display("card light and interrupt done");
        wr(`SID_OFF_CTRL, 32'h2);
        tog(7, 4);
        set(9, 1);
        @(posedge clk_i);
        #1 chk(ack, 1'h1);
        set(9, 0);
        set(8, 1);
        tog(8, 4);
        chk(lt[7] ^ lt[8], 1'h1);
        set(8, 0);
        $display("module state light done");
        set(2, 1);
        rd(`SID_OFF_FAULT, 32'h3C);
        set(2, 0);
        rd(`SID_OFF_IRQ, 32'h2);
        wr(`SID_OFF_CTRL, 32'h3);
        set(2, 1);
        rd(`SID_OFF_FAULT, 32'h3D);
        set(2, 0);
        set(1, 1);
        @(posedge clk_i);
        #1 chk(clr, 1'h1);
        @(posedge clk_i);
        #1 chk(clr, 1'h0);
        tog(1, 0);
        chk(lt[1:0], 2'h2);
        $display("fault handling done");
        conclude;
    end
endmodule // sid_status_lights_tb
bind sid_status_lights sid_chk sid_chk_inst (.clk_i, .nrst_i, .major_fault_i, .nv_busy_i, .card_busy_i,
    .card_bad_fs_i, .port0_default_i, .port0_activity_i, .health_green_o, .health_red_o,
    .card_activity_light_green_o, .default_port_config_light_o, .port0_traffic_light_o, .project_clear_o);
